/* rtl/crs_pkg.sv */
// Constants and types for the CAN reset-state and interrupt-enable block.
// Assumes a classic Wishbone master and a protocol engine on the same clock.
// Operation
// - Bus timing, output control and transmit buffer survive every kind of reset.
// - Hardware reset loads clock divider with 00h or 05h by host bus style.
// - Reading the command location always returns all ones.
// - Entering bus-off sets the error interrupt flag when its enable is set.
// - Every reset returns receive queue read and write pointers to initial values.
// - Transmitted frame is echoed into receive buffer without interrupt or lock.
// - Hardware reset puts receive queue pointers at RAM address zero.
// - Software or bus-off reset puts pointers at the current queue start address.
// - Control register sits at address 0, readable and writable by the host.
// - Overrun interrupt only when overrun enable bit 4 is set and overrun occurs.
// - Error interrupt on error or bus status change only when bit 3 set.
// - Transmit interrupt on success or buffer release only when bit 2 set.
// - Reset request aborts traffic and holds reset mode; clearing resumes operation.
// - Reset request is forced to one by hardware reset and by bus-off.
package crs_pkg;

	// Register byte addresses
	localparam logic [7:0] ADR_CONTROL     = 8'h00;
	localparam logic [7:0] ADR_COMMAND     = 8'h04;
	localparam logic [7:0] ADR_TIMING0     = 8'h08;
	localparam logic [7:0] ADR_TIMING1     = 8'h0c;
	localparam logic [7:0] ADR_OUTCTL      = 8'h10;
	localparam logic [7:0] ADR_CLKDIV      = 8'h14;
	localparam logic [7:0] ADR_IRQ_STATUS  = 8'h18;
	localparam logic [7:0] ADR_IRQ_MASK    = 8'h1c;
	localparam logic [7:0] ADR_CORE_STATUS = 8'h20;
	localparam logic [7:0] ADR_RX_WINDOW   = 8'h24;
	localparam logic [7:0] ADR_RX_START    = 8'h28;
	localparam logic [7:0] ADR_TX_BASE     = 8'h40;

	// Control register fields
	localparam int CR_RESET_REQ = 0;
	localparam int CR_TX_IE     = 2;
	localparam int CR_ERR_IE    = 3;
	localparam int CR_OVR_IE    = 4;
	localparam int CR_RES5      = 5;
	localparam int CR_RES6      = 6;
	localparam logic [7:0] CR_HW_RESET = 8'h21;

	// Command strobe fields
	localparam int CMD_TX_REQ  = 0;
	localparam int CMD_ABORT   = 1;
	localparam int CMD_RELEASE = 2;
	localparam int CMD_CLR_OVR = 3;
	localparam logic [7:0] CMD_READ_VALUE = 8'hff;

	// Clock divider values after hardware reset
	localparam logic [7:0] CDR_RESET_STYLE0 = 8'h00;
	localparam logic [7:0] CDR_RESET_STYLE1 = 8'h05;

	// Interrupt status and mask layout
	localparam int IRQ_TX   = 0;
	localparam int IRQ_ERR  = 1;
	localparam int IRQ_OVR  = 2;
	localparam int IRQ_BITS = 3;
	localparam logic [IRQ_BITS-1:0] IRQ_MASK_RESET = 3'h0;

	// Core status fields
	localparam int ST_BUS_OFF  = 7;
	localparam int ST_ERROR    = 6;
	localparam int ST_COPYING  = 3;
	localparam int ST_TX_FREE  = 2;
	localparam int ST_OVERRUN  = 1;

	// Buffer sizes
	localparam int TX_LEN       = 10;
	localparam int RX_DEPTH     = 64;
	localparam int RX_FRAME_LEN = 10;

	typedef enum logic {CP_IDLE, CP_COPY} crs_copy_t;

	typedef struct packed {
		logic [7:0] timing0;
		logic [7:0] timing1;
		logic [7:0] outctl;
		logic [7:0] clkdiv;
	} crs_cfg_t;

	typedef struct packed {
		logic       bus_off;
		logic       error_status;
		logic       overrun;
		logic       tx_success;
		logic       tx_aborted;
		logic       rx_valid;
		logic [7:0] rx_byte;
	} crs_evt_t;

endpackage

/* rtl/crs_sticky.sv */
// Sticky flag: set by hardware, cleared by software.
// Assumes set and clear come from the same clock domain.
`timescale 1ns/1ps
module crs_sticky (
	// Clock and reset
	input  wire logic mclk_in,
	input  wire logic rst_n_in,
	// Control
	input  wire logic set_in,
	input  wire logic clr_in,
	// Flag
	output logic      flag_out
);
	logic next_flag;

	always_comb begin
		next_flag = flag_out;
		if (clr_in) begin
			next_flag = 1'b0;
		end
		// Set wins over a clear in the same cycle
		if (set_in) begin
			next_flag = 1'b1;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			flag_out <= 1'b0;
		end else begin
			flag_out <= next_flag;
		end
	end
endmodule // crs_sticky

/* rtl/crs_ctrl.sv */
// Register file, reset handling, receive queue pointers and interrupts.
// Assumes a Wishbone classic master and a protocol engine on mclk_in.
//
// Our own choice: the Wishbone slave port.
`timescale 1ns/1ps
module crs_ctrl #(
	parameter int TX_LEN       = crs_pkg::TX_LEN,
	parameter int RX_DEPTH     = crs_pkg::RX_DEPTH,
	parameter int RX_FRAME_LEN = crs_pkg::RX_FRAME_LEN
) (
	// Clock and reset
	input  wire logic              mclk_in,
	input  wire logic              rst_n_in,
	// Host bus style strap pin
	input  wire logic              host_style_in,
	// Wishbone slave
	input  wire logic              wb_cyc_in,
	input  wire logic              wb_stb_in,
	input  wire logic              wb_we_in,
	input  wire logic [7:0]        wb_adr_in,
	input  wire logic [3:0]        wb_sel_in,
	input  wire logic [31:0]       wb_dat_in,
	output logic [31:0]            wb_dat_out,
	output logic                   wb_ack_out,
	// Protocol engine
	input  wire crs_pkg::crs_evt_t evt_in,
	output crs_pkg::crs_cfg_t      cfg_out,
	output logic                   reset_mode_out,
	output logic                   tx_request_out,
	output logic                   abort_out,
	// Interrupt
	output logic                   irq_out
);
	import crs_pkg::*;

	localparam int PW = $clog2(RX_DEPTH);
	localparam int TW = $clog2(TX_LEN);

	////////////////////////////////////////////////////////////////////////
	// Declarations

	logic                style_meta, style_sync;
	logic [7:0]          control, next_control;
	logic [7:0]          timing0, next_timing0, timing1, next_timing1;
	logic [7:0]          outctl, next_outctl, clkdiv, next_clkdiv;
	logic [7:0]          txbuf [TX_LEN], next_txbuf [TX_LEN];
	logic [7:0]          rx_mem [RX_DEPTH], next_rx_mem [RX_DEPTH];
	logic                cdr_load_pending;
	logic [IRQ_BITS-1:0] irq_mask, next_irq_mask, irq_status, irq_set, irq_clr;
	logic                overrun_st, next_overrun_st, tx_free, next_tx_free;
	logic [1:0]          prev_stat;
	logic [PW-1:0]       rx_start, next_rx_start, rx_wr, next_rx_wr, rx_rd, next_rx_rd;
	logic [PW-1:0]       copy_ptr, next_copy_ptr;
	logic [TW-1:0]       copy_idx, next_copy_idx;
	crs_copy_t           copy_state, next_copy_state;
	logic                next_ack, next_tx_request, next_abort, next_irq;
	logic [31:0]         next_dat;
	logic                bus_wr, bus_rd, tx_hit;
	logic [3:0]          tx_idx;
	logic [7:0]          cmd;

	////////////////////////////////////////////////////////////////////////
	// Strap synchroniser and bus decode

	always_ff @(posedge mclk_in) begin
		style_meta <= host_style_in;
		style_sync <= style_meta;
	end

	// Writes and side-effecting reads act on the edge that sees ack
	assign bus_wr = wb_cyc_in && wb_stb_in && wb_ack_out && wb_we_in && wb_sel_in[0];
	assign bus_rd = wb_cyc_in && wb_stb_in && wb_ack_out && !wb_we_in;
	assign tx_idx = wb_adr_in[5:2];
	assign tx_hit = (wb_adr_in[7:6] == ADR_TX_BASE[7:6]) && (wb_adr_in[1:0] == 2'h0)
		&& (32'(tx_idx) < 32'(TX_LEN));
	assign cmd    = (bus_wr && wb_adr_in == ADR_COMMAND) ? wb_dat_in[7:0] : 8'h00;

	////////////////////////////////////////////////////////////////////////
	// Retained registers: no reset branch; all but clkdiv survive every reset

	always_comb begin
		next_timing0 = timing0;
		next_timing1 = timing1;
		next_outctl  = outctl;
		next_clkdiv  = clkdiv;
		next_txbuf   = txbuf;
		if (cdr_load_pending) begin
			next_clkdiv = style_sync ? CDR_RESET_STYLE1 : CDR_RESET_STYLE0;
		end else if (bus_wr && wb_adr_in == ADR_CLKDIV) begin
			next_clkdiv = wb_dat_in[7:0];
		end
		if (bus_wr) begin
			unique case (wb_adr_in)
				ADR_TIMING0: next_timing0 = wb_dat_in[7:0];
				ADR_TIMING1: next_timing1 = wb_dat_in[7:0];
				ADR_OUTCTL:  next_outctl  = wb_dat_in[7:0];
				default: begin
					if (tx_hit) begin
						next_txbuf[tx_idx] = wb_dat_in[7:0];
					end
				end
			endcase
		end
	end

	always_ff @(posedge mclk_in) begin
		timing0 <= next_timing0;
		timing1 <= next_timing1;
		outctl  <= next_outctl;
		clkdiv  <= next_clkdiv;
		txbuf   <= next_txbuf;
	end

	assign cfg_out = '{timing0: timing0, timing1: timing1, outctl: outctl, clkdiv: clkdiv};

	////////////////////////////////////////////////////////////////////////
	// Control, queue pointers, echo copy and events

	always_comb begin
		next_control    = control;
		next_irq_mask   = irq_mask;
		next_overrun_st = overrun_st;
		next_tx_free    = tx_free;
		next_rx_start   = rx_start;
		next_rx_wr      = rx_wr;
		next_rx_rd      = rx_rd;
		next_rx_mem     = rx_mem;
		next_copy_state = copy_state;
		next_copy_ptr   = copy_ptr;
		next_copy_idx   = copy_idx;
		next_tx_request = 1'b0;
		next_abort      = 1'b0;
		irq_set         = '0;
		irq_clr         = '0;
		if (bus_wr && wb_adr_in == ADR_CONTROL) begin
			next_control = {1'b0, wb_dat_in[6], 1'b1, wb_dat_in[4:0]};
		end
		if (bus_wr && wb_adr_in == ADR_IRQ_MASK) begin
			next_irq_mask = wb_dat_in[IRQ_BITS-1:0];
		end
		if (bus_wr && wb_adr_in == ADR_IRQ_STATUS) begin
			irq_clr = wb_dat_in[IRQ_BITS-1:0];
		end
		if (evt_in.bus_off) begin
			next_control[CR_RESET_REQ] = 1'b1;
		end
		// Error or bus status change
		if ({evt_in.bus_off, evt_in.error_status} != prev_stat && control[CR_ERR_IE]) begin
			irq_set[IRQ_ERR] = 1'b1;
		end
		if (cmd[CMD_CLR_OVR]) begin
			next_overrun_st = 1'b0;
		end
		// No further overrun interrupt while overrun status stands
		if (evt_in.overrun && !overrun_st) begin
			next_overrun_st  = 1'b1;
			irq_set[IRQ_OVR] = control[CR_OVR_IE];
		end
		if (evt_in.tx_success || evt_in.tx_aborted) begin
			next_tx_free    = 1'b1;
			irq_set[IRQ_TX] = control[CR_TX_IE];
		end
		if (evt_in.tx_success) begin
			next_copy_state = CP_COPY;
			next_copy_ptr   = rx_wr;
			next_copy_idx   = '0;
		end
		if (control[CR_RESET_REQ]) begin
			// Reset mode: no traffic, pointers held at the start address
			next_copy_state = CP_IDLE;
			next_tx_free    = 1'b1;
			next_rx_wr      = rx_start;
			next_rx_rd      = rx_start;
		end else begin
			if (cmd[CMD_TX_REQ] && tx_free) begin
				next_tx_request = 1'b1;
				next_tx_free    = 1'b0;
			end
			next_abort = cmd[CMD_ABORT];
			if (cmd[CMD_RELEASE]) begin
				next_rx_start = rx_start + PW'(RX_FRAME_LEN);
				next_rx_rd    = rx_start + PW'(RX_FRAME_LEN);
			end else if (bus_rd && wb_adr_in == ADR_RX_WINDOW) begin
				next_rx_rd = rx_rd + 1'b1;
			end
			if (evt_in.rx_valid) begin
				next_rx_mem[rx_wr] = evt_in.rx_byte;
				next_rx_wr         = rx_wr + 1'b1;
			end else if (copy_state == CP_COPY && !evt_in.tx_success) begin
				// Echo does not move the write pointer and raises no flag
				next_rx_mem[copy_ptr] = txbuf[copy_idx];
				next_copy_ptr         = copy_ptr + 1'b1;
				next_copy_idx         = copy_idx + 1'b1;
				if (32'(copy_idx) == TX_LEN - 1) begin
					next_copy_state = CP_IDLE;
				end
			end
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			control          <= CR_HW_RESET;
			cdr_load_pending <= 1'b1;
			irq_mask         <= IRQ_MASK_RESET;
			overrun_st       <= 1'b0;
			tx_free          <= 1'b1;
			prev_stat        <= 2'h0;
			rx_start         <= '0;
			rx_wr            <= '0;
			rx_rd            <= '0;
			copy_state       <= CP_IDLE;
			copy_ptr         <= '0;
			copy_idx         <= '0;
			tx_request_out   <= 1'b0;
			abort_out        <= 1'b0;
		end else begin
			control          <= next_control;
			cdr_load_pending <= 1'b0;
			irq_mask         <= next_irq_mask;
			overrun_st       <= next_overrun_st;
			tx_free          <= next_tx_free;
			prev_stat        <= {evt_in.bus_off, evt_in.error_status};
			rx_start         <= next_rx_start;
			rx_wr            <= next_rx_wr;
			rx_rd            <= next_rx_rd;
			copy_state       <= next_copy_state;
			copy_ptr         <= next_copy_ptr;
			copy_idx         <= next_copy_idx;
			tx_request_out   <= next_tx_request;
			abort_out        <= next_abort;
		end
	end

	// Queue contents are undefined after reset and are not cleared
	always_ff @(posedge mclk_in) begin
		rx_mem <= next_rx_mem;
	end

	assign reset_mode_out = control[CR_RESET_REQ];

	for (genvar i = 0; i < IRQ_BITS; i++) begin : g_flag
		crs_sticky u_flag (
			.mclk_in  (mclk_in),
			.rst_n_in (rst_n_in),
			.set_in   (irq_set[i]),
			.clr_in   (irq_clr[i]),
			.flag_out (irq_status[i])
		);
	end

	////////////////////////////////////////////////////////////////////////
	// Bus answer and interrupt output

	always_comb begin
		next_ack = wb_cyc_in && wb_stb_in && !wb_ack_out;
		next_irq = |(irq_status & irq_mask);
		next_dat = 32'h0;
		unique case (wb_adr_in)
			ADR_CONTROL:     next_dat[7:0] = control;
			ADR_COMMAND:     next_dat[7:0] = CMD_READ_VALUE;
			ADR_TIMING0:     next_dat[7:0] = timing0;
			ADR_TIMING1:     next_dat[7:0] = timing1;
			ADR_OUTCTL:      next_dat[7:0] = outctl;
			ADR_CLKDIV:      next_dat[7:0] = clkdiv;
			ADR_IRQ_STATUS:  next_dat[IRQ_BITS-1:0] = irq_status;
			ADR_IRQ_MASK:    next_dat[IRQ_BITS-1:0] = irq_mask;
			ADR_CORE_STATUS: begin
				next_dat[ST_BUS_OFF] = evt_in.bus_off;
				next_dat[ST_ERROR]   = evt_in.error_status;
				next_dat[ST_COPYING] = (copy_state == CP_COPY);
				next_dat[ST_TX_FREE] = tx_free;
				next_dat[ST_OVERRUN] = overrun_st;
			end
			ADR_RX_WINDOW:   next_dat[7:0] = rx_mem[rx_rd];
			ADR_RX_START:    next_dat[PW-1:0] = rx_start;
			default: begin
				if (tx_hit) begin
					next_dat[7:0] = txbuf[tx_idx];
				end
			end
		endcase
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			wb_ack_out <= 1'b0;
			wb_dat_out <= 32'h0;
			irq_out    <= 1'b0;
		end else begin
			wb_ack_out <= next_ack;
			wb_dat_out <= next_dat;
			irq_out    <= next_irq;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Assertions

	a_cmd_reads_ones: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		(wb_cyc_in && wb_stb_in && !wb_we_in && !wb_ack_out && wb_adr_in == ADR_COMMAND)
		|=> wb_ack_out && wb_dat_out[7:0] == 8'hff)
		else $error("command read not all ones");

	a_busoff_forces_rr: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		evt_in.bus_off |=> control[CR_RESET_REQ] && reset_mode_out)
		else $error("bus-off did not set reset request");

	a_busoff_err_flag: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		($rose(evt_in.bus_off) && control[CR_ERR_IE]) |=> irq_status[IRQ_ERR])
		else $error("bus-off did not set error flag");

	a_err_flag_off: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		(!irq_status[IRQ_ERR] && !control[CR_ERR_IE]) |=> !irq_status[IRQ_ERR])
		else $error("error flag set while disabled");

	a_ovr_enabled: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		(evt_in.overrun && !overrun_st && control[CR_OVR_IE]) |=> irq_status[IRQ_OVR] && overrun_st)
		else $error("overrun flag missing");

	a_tx_irq_set: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		(evt_in.tx_success && control[CR_TX_IE]) |=> irq_status[IRQ_TX] && tx_free)
		else $error("transmit flag missing");

	a_soft_ptr_reset: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		control[CR_RESET_REQ] |=> rx_rd == $past(rx_start) && rx_wr == $past(rx_start))
		else $error("pointers not at start address");

	a_hw_ptr_zero: assert property (@(posedge mclk_in)
		$rose(rst_n_in) |-> rx_wr == '0 && rx_rd == '0 && rx_start == '0)
		else $error("pointers not zero after reset");

	a_cdr_style: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		cdr_load_pending |=> clkdiv == ($past(style_sync) ? 8'h05 : 8'h00))
		else $error("clock divider reset value wrong");

	a_echo_no_move: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		(copy_state == CP_COPY && !evt_in.rx_valid && !evt_in.tx_success && !control[CR_RESET_REQ])
		|=> rx_wr == $past(rx_wr) && copy_ptr == $past(copy_ptr) + 1'b1)
		else $error("echo moved write pointer");

	a_irq_level: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		|(irq_status & irq_mask) |=> irq_out)
		else $error("interrupt output not raised");

	a_retained: assert property (@(posedge mclk_in)
		(!rst_n_in && !cdr_load_pending) |=> timing1 == $past(timing1) && outctl == $past(outctl))
		else $error("retained register changed by reset");
endmodule // crs_ctrl

/* test/crs_engine_model.sv */
// Behavioural protocol engine driving the event struct of the control block.
// Assumes the control block's command pulses on the same clock.
`timescale 1ns/1ps
module crs_engine_model
	import crs_pkg::*;
(
	// Clock and reset
	input  wire logic     mclk_in,
	input  wire logic     rst_n_in,
	// From the control block
	input  wire logic     tx_request_in,
	input  wire logic     abort_in,
	input  wire logic     reset_mode_in,
	// Bench controls
	input  wire logic     bus_off_in,
	input  wire logic     error_in,
	input  wire logic     overrun_in,
	input  wire logic     slow_in,
	// Events
	output crs_evt_t      evt_out
);
	logic       busy;
	logic [3:0] cnt;
	logic       done;
	logic       aborted;
	logic [7:0] noise;

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge mclk_in) begin
		done    <= 1'b0;
		aborted <= 1'b0;
		noise   <= noise + 8'h35;
		if (!rst_n_in) begin
			busy  <= 1'b0;
			cnt   <= 4'h0;
			noise <= 8'h5a;
		end else if (reset_mode_in) begin
			busy <= 1'b0;
		end else if (abort_in && busy) begin
			busy    <= 1'b0;
			aborted <= 1'b1;
		end else if (tx_request_in && !busy) begin
			busy <= 1'b1;
			cnt  <= slow_in ? 4'h8 : 4'h1;
		end else if (busy) begin
			cnt <= cnt - 4'h1;
			if (cnt == 4'h1) begin
				busy <= 1'b0;
				done <= 1'b1;
			end
		end
	end

	// Receive path idle: byte lane toggles so stale data is never trusted
	assign evt_out = {bus_off_in, error_in, overrun_in, done, aborted, 1'b0, noise};
endmodule // crs_engine_model

/* test/crs_ctrl_tb.sv */
// Self-checking bench for the reset-state and interrupt-enable block.
// Assumes the engine model beside it and a Wishbone classic slave.
`timescale 1ns/1ps
module crs_ctrl_tb;
	import crs_pkg::*;
	logic        mclk_in = 1'b0;
	logic        rst_n_in = 1'b0;
	logic        style = 1'b1;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] dat = 32'h0;
	logic        bus_off = 1'b0;
	logic        err = 1'b0;
	logic        ovr = 1'b0;
	logic        slow = 1'b0;
	logic [31:0] wb_dat_out;
	logic        wb_ack_out;
	crs_evt_t    evt;
	crs_cfg_t    cfg_out;
	logic        reset_mode_out;
	logic        tx_request_out;
	logic        abort_out;
	logic        irq_out;
	logic [7:0]  q;
	int          err_count = 0;
	int          n_checks = 0;
	int          n_txreq = 0;
	int          n_abort = 0;

	initial begin
		forever #50 mclk_in = ~mclk_in;
	end

	crs_ctrl DUT (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .host_style_in(style), .wb_cyc_in(cyc),
		.wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hf), .wb_dat_in(dat),
		.wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .evt_in(evt), .cfg_out(cfg_out),
		.reset_mode_out(reset_mode_out), .tx_request_out(tx_request_out), .abort_out(abort_out),
		.irq_out(irq_out));
	crs_engine_model eng (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .tx_request_in(tx_request_out),
		.abort_in(abort_out), .reset_mode_in(reset_mode_out), .bus_off_in(bus_off), .error_in(err),
		.overrun_in(ovr), .slow_in(slow), .evt_out(evt));

	// Pulse counters for the engine command outputs
	always @(posedge mclk_in) begin
		if (tx_request_out === 1'b1) n_txreq <= n_txreq + 1;
		if (abort_out === 1'b1) n_abort <= n_abort + 1;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d);
		@(posedge mclk_in);
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		adr <= a;
		dat <= {24'h0, d};
		do begin
			@(posedge mclk_in);
		end while (wb_ack_out !== 1'b1);
		q = wb_dat_out[7:0];
		check("read upper", {8'h0, wb_dat_out[31:8]}, 32'h0);
		cyc <= 1'b0;
		stb <= 1'b0;
		we  <= 1'b0;
		@(posedge mclk_in);
		check("bus ack", {31'h0, wb_ack_out}, 32'h0);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		wb(a, 1'b1, d);
	endtask

	task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
		wb(a, 1'b0, 8'h00);
		check(what, {24'h0, q}, {24'h0, exp});
	endtask

	task automatic hw_reset(input logic s);
		style    <= s;
		rst_n_in <= 1'b0;
		repeat (10) @(posedge mclk_in);
		rst_n_in <= 1'b1;
	endtask

	task automatic wait_irq();
		for (int i = 0; i < 40 && irq_out !== 1'b1; i++) @(posedge mclk_in);
		check("irq wait", {31'h0, irq_out}, 32'h1);
	endtask

	task automatic pulse_ovr();
		@(posedge mclk_in);
		ovr <= 1'b1;
		@(posedge mclk_in);
		ovr <= 1'b0;
	endtask

	task automatic conclude();
		$display("Checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge mclk_in);
		err_count++;
		conclude();
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		hw_reset(1'b1);
		rchk("control", ADR_CONTROL, 8'h21);
		rchk("divider", ADR_CLKDIV, CDR_RESET_STYLE1);
		rchk("command", ADR_COMMAND, 8'hff);
		rchk("mask", ADR_IRQ_MASK, 8'h00);
		rchk("rx start", ADR_RX_START, 8'h00);
		rchk("unmapped", 8'h3c, 8'h00);
		wr(ADR_TIMING0, 8'h5a);
		wr(ADR_TIMING1, 8'hc3);
		wr(ADR_OUTCTL, 8'h96);
		for (int i = 0; i < TX_LEN; i++) wr(ADR_TX_BASE + 8'(4 * i), 8'ha0 + 8'(i));
		wr(ADR_IRQ_MASK, 8'h07);
		wr(ADR_CONTROL, 8'h5c);
		rchk("control rw", ADR_CONTROL, 8'h7c);
		// Transmit, echo and release
		wr(ADR_COMMAND, 8'h01);
		wait_irq();
		check("irq tx", {31'h0, irq_out}, 32'h1);
		rchk("status tx", ADR_IRQ_STATUS, 8'h01);
		repeat (15) @(posedge mclk_in);
		for (int i = 0; i < RX_FRAME_LEN; i++) rchk("echo", ADR_RX_WINDOW, 8'ha0 + 8'(i));
		wr(ADR_IRQ_STATUS, 8'h01);
		repeat (3) @(posedge mclk_in);
		check("irq clear", {31'h0, irq_out}, 32'h0);
		slow <= 1'b1;
		wr(ADR_COMMAND, 8'h01);
		wr(ADR_COMMAND, 8'h02);
		wait_irq();
		rchk("status abort", ADR_IRQ_STATUS, 8'h01);
		wr(ADR_IRQ_STATUS, 8'h01);
		wr(ADR_COMMAND, 8'h04);
		rchk("start moved", ADR_RX_START, 8'h0a);
		// Error and overrun with enables set, then masked
		err <= 1'b1;
		wait_irq();
		rchk("status err", ADR_IRQ_STATUS, 8'h02);
		wr(ADR_IRQ_STATUS, 8'h02);
		pulse_ovr();
		wait_irq();
		rchk("status ovr", ADR_IRQ_STATUS, 8'h04);
		wr(ADR_COMMAND, 8'h08);
		wr(ADR_IRQ_STATUS, 8'h04);
		wr(ADR_IRQ_MASK, 8'h00);
		err <= 1'b0;
		repeat (4) @(posedge mclk_in);
		check("irq masked", {31'h0, irq_out}, 32'h0);
		rchk("status masked", ADR_IRQ_STATUS, 8'h02);
		wr(ADR_IRQ_STATUS, 8'h02);
		wr(ADR_IRQ_MASK, 8'h07);
		// Enables cleared: no flags
		wr(ADR_CONTROL, 8'h40);
		slow <= 1'b0;
		wr(ADR_COMMAND, 8'h01);
		pulse_ovr();
		err <= 1'b1;
		repeat (12) @(posedge mclk_in);
		rchk("status off", ADR_IRQ_STATUS, 8'h00);
		// Bus-off forces reset mode
		wr(ADR_CONTROL, 8'h48);
		bus_off <= 1'b1;
		wait_irq();
		rchk("status busoff", ADR_IRQ_STATUS, 8'h02);
		rchk("control busoff", ADR_CONTROL, 8'h69);
		rchk("core busoff", ADR_CORE_STATUS, 8'hc6);
		check("mode busoff", {31'h0, reset_mode_out}, 32'h1);
		check("cfg busoff", cfg_out, {8'h5a, 8'hc3, 8'h96, 8'h05});
		rchk("start busoff", ADR_RX_START, 8'h0a);
		bus_off <= 1'b0;
		err <= 1'b0;
		wr(ADR_IRQ_STATUS, 8'h07);
		// Software reset: commands refused, divider kept
		wr(ADR_CONTROL, 8'h05);
		wr(ADR_COMMAND, 8'h01);
		repeat (12) @(posedge mclk_in);
		rchk("status rmode", ADR_IRQ_STATUS, 8'h00);
		rchk("divider sw", ADR_CLKDIV, CDR_RESET_STYLE1);
		// Hardware reset in the other host style
		hw_reset(1'b0);
		rchk("divider hw", ADR_CLKDIV, CDR_RESET_STYLE0);
		rchk("timing0", ADR_TIMING0, 8'h5a);
		rchk("timing1", ADR_TIMING1, 8'hc3);
		rchk("outctl", ADR_OUTCTL, 8'h96);
		rchk("txbuf", ADR_TX_BASE, 8'ha0);
		rchk("start hw", ADR_RX_START, 8'h00);
		rchk("control hw", ADR_CONTROL, 8'h21);
		check("tx requests", n_txreq, 32'd3);
		check("aborts", n_abort, 32'd1);
		conclude();
	end
endmodule // crs_ctrl_tb
